// ### verilog/ccl_pkg.sv
// Shared constants and types of the card call-in link controller.
// Assumes a byte-wide command/response transport to the card below this block.
`default_nettype none
package ccl_pkg;
	typedef enum logic [1:0] {
		CCL_IDLE   = 2'b00,
		CCL_CALLIN = 2'b01,
		CCL_COMM   = 2'b10
	} ccl_state_e;
	localparam logic [7:0] CMD_POLL       = 8'h01;
	localparam logic [7:0] CMD_REQ_DATA   = 8'h02;
	localparam logic [7:0] CMD_CENTER_RSP = 8'h03;
	localparam logic [7:0] CMD_REPORT     = 8'h04;
	localparam logic [7:0] CMD_USER_CALL  = 8'h05;
	localparam logic [15:0] INS_CALLIN     = 16'h0001;
	localparam logic [15:0] INS_DISCONNECT = 16'h0002;
	localparam logic [15:0] INS_CENTER_ERR = 16'h0003;
	localparam logic [15:0] INS_RETRIES    = 16'h0004;
	localparam logic [7:0] STS_COMPLETE     = 8'h00;
	localparam logic [7:0] STS_FAILED       = 8'h01;
	localparam logic [7:0] STS_DISCONNECTED = 8'h02;
	localparam logic [3:0] HDR_INSTR_HI = 4'h2;
	localparam logic [3:0] HDR_INSTR_LO = 4'h3;
	localparam logic [3:0] HDR_PDU      = 4'h6;
	localparam logic [3:0] HDR_FINAL    = 4'h7;
	localparam logic [3:0] HDR_DATA     = 4'h8;
	localparam logic [7:0] CMD_POS_LC   = 8'h00;
	localparam logic [7:0] CMD_POS_PDU  = 8'h01;
	localparam logic [7:0] CMD_POS_CODE = 8'h02;
	localparam logic [7:0] CMD_HDR_LEN  = 8'h03;
	localparam logic [7:0] LEN_STATUS   = 8'h01;
	localparam int         PART_BYTES   = 16;
	localparam logic [4:0] PART_FULL    = 5'h10;
	localparam int         FIFO_WIDTH   = 9;
	localparam int         FIFO_DEPTH   = 4;
	typedef struct packed {
		ccl_state_e              st;
		logic                    busy;
		logic [7:0]              kind;
		logic [7:0]              pdu;
		logic [7:0]              len;
		logic [7:0]              idx;
		logic [7:0]              status;
		logic                    cmd_v;
		logic [7:0]              cmd_d;
		logic                    cmd_l;
		logic                    rsp_rdy;
		logic [3:0]              ridx;
		logic [15:0]             instr;
		logic [7:0]              rpdu;
		logic [7:0]              rfin;
		logic                    retries;
		logic                    conn_p;
		logic                    fail_p;
		logic                    fault_p;
		logic                    drop_wait;
		logic                    dial;
		logic                    hangup;
		logic [PART_BYTES-1:0][7:0] buf_d;
		logic [4:0]              buf_cnt;
		logic                    flush;
		logic                    flush_end;
		logic [7:0]              part_no;
		logic                    ctr_rdy;
		logic                    push_v;
		logic [8:0]              push_d;
	} ccl_state_s;
endpackage : ccl_pkg
`default_nettype wire

// ### verilog/ccl_ctrl.sv
// Card call-in link controller: receiver-side master of the card link.
// Assumes the card transport delivers framed command and response bytes.
//
// How it works
// [R1] Receiver is always master, card always slave; roles never swap.
// [R2] One command outstanding; its single response must end before the next.
// [R3] Each command starts with a length byte then the PDU number byte.
// [R4] Card response header: type, length, instruction, return code, PDU, final PDU.
// [R5] Card link below uses the block half-duplex type one transport.
// [R6] Nonzero final PDU: fetch next PDUs in order until PDU equals final.
// [R7] Receiver fills the PDU field in data, relay and status commands.
// [R8] Center data is cut into numbered partitions sent to the card.
// [R9] Call-in instruction while idle starts dialing and enters call-in.
// [R10] Connection made: report complete to card, enter communications.
// [R11] Dial failure: report call-in failed to card, return to idle.
// [R12] Repeated call-in instructions before the status report are dropped.
// [R13] Card reports retries exceeded after failed connection attempts.
// [R14] User call-in command is sent only after retries exceeded.
// [R15] Card asks call-in on schedule, forced message, full history or user.
// [R16] Relay card data with final PDU zero straight to the center.
// [R17] Nonzero final PDU: request data until last part, then forward; the code relays each part's data as it arrives.
// [R18] Center data reaches the card by the center-response command.
// [R19] Relayed data passes through without being interpreted.
// [R20] Card reports center communications error instead of disconnect.
// [R21] Link fault: report disconnected, hang up when card says disconnect.
// [R22] Disconnect during call-in cancels it; ignored while idle.
// [R23] Disconnect during communications hangs up and returns to idle.
// [R24] Unlisted events change nothing and send no command.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// FIFO
// ----------------------------------------------------------------------------
module ccl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output var  logic             in_ready_o,
	output var  logic             out_valid_o,
	output var  logic [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
		logic                        rdy;
		logic                        vld;
		logic [WIDTH-1:0]            dout;
	} ccl_fifo_s;
	ccl_fifo_s f_reg;
	ccl_fifo_s f_next;
	logic push;
	logic pop;

	always_comb begin
		f_next = f_reg;
		push = in_valid_i && f_reg.rdy;
		pop = out_ready_i && (f_reg.cnt != '0);
		if (push) begin
			f_next.mem[f_reg.wr] = in_data_i;
			f_next.wr = (f_reg.wr == PW'(DEPTH - 1)) ? '0 : f_reg.wr + 1'b1;
		end
		if (pop) begin
			f_next.rd = (f_reg.rd == PW'(DEPTH - 1)) ? '0 : f_reg.rd + 1'b1;
		end
		f_next.cnt = f_reg.cnt + CW'(push) - CW'(pop);
		f_next.rdy = (f_next.cnt != FULL);
		f_next.vld = (f_next.cnt != '0);
		f_next.dout = f_next.mem[f_next.rd];
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

	assign in_ready_o = f_reg.rdy;
	assign out_valid_o = f_reg.vld;
	assign out_data_o = f_reg.dout;
endmodule : ccl_fifo

// ----------------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------------
module ccl_ctrl (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	output var  logic       cmd_valid_o,
	output var  logic [7:0] cmd_data_o,
	output var  logic       cmd_last_o,
	input  wire logic       cmd_ready_i,
	input  wire logic       rsp_valid_i,
	input  wire logic [7:0] rsp_data_i,
	input  wire logic       rsp_last_i,
	output var  logic       rsp_ready_o,
	input  wire logic       poll_i,
	input  wire logic       user_callin_i,
	output var  logic       dial_o,
	input  wire logic       connected_i,
	input  wire logic       dial_fail_i,
	input  wire logic       comm_fault_i,
	output var  logic       hangup_o,
	input  wire logic       ctr_in_valid_i,
	input  wire logic [7:0] ctr_in_data_i,
	input  wire logic       ctr_in_last_i,
	output var  logic       ctr_in_ready_o,
	output var  logic       ctr_out_valid_o,
	output var  logic [7:0] ctr_out_data_o,
	output var  logic       ctr_out_last_o,
	input  wire logic       ctr_out_ready_i,
	output var  logic [1:0] state_o
);
	ccl_pkg::ccl_state_s s_reg;
	ccl_pkg::ccl_state_s s_next;
	logic                fifo_rdy;
	logic [8:0]          fifo_out;

	function automatic logic [7:0] cmd_byte(input ccl_pkg::ccl_state_s s, input logic [7:0] i);
		logic [7:0] b;
		b = s.buf_d[4'(i - ccl_pkg::CMD_HDR_LEN)];
		if (s.kind == ccl_pkg::CMD_REPORT) begin
			b = s.status;
		end
		case (i)
			ccl_pkg::CMD_POS_LC:   cmd_byte = s.len + 8'h01;
			ccl_pkg::CMD_POS_PDU:  cmd_byte = s.pdu;
			ccl_pkg::CMD_POS_CODE: cmd_byte = s.kind;
			default:               cmd_byte = b;
		endcase
	endfunction : cmd_byte

	function automatic logic relay_kind(input logic [7:0] k);
		relay_kind = (k == ccl_pkg::CMD_CENTER_RSP) || (k == ccl_pkg::CMD_REQ_DATA);
	endfunction : relay_kind

	always_comb begin
		logic        launch;
		logic        take;
		logic [15:0] ins;
		logic [7:0]  fin;
		logic [7:0]  pn;
		s_next = s_reg;
		launch = 1'b0;
		take = 1'b0;
		ins = s_reg.instr;
		fin = s_reg.rfin;
		pn = s_reg.rpdu;
		s_next.dial = 1'b0;
		s_next.hangup = 1'b0;
		s_next.conn_p = s_reg.conn_p | (connected_i && s_reg.st == ccl_pkg::CCL_CALLIN);
		s_next.fail_p = s_reg.fail_p | (dial_fail_i && s_reg.st == ccl_pkg::CCL_CALLIN);
		s_next.fault_p = s_reg.fault_p | (comm_fault_i && s_reg.st == ccl_pkg::CCL_COMM);
		if (s_reg.push_v && fifo_rdy) begin
			s_next.push_v = 1'b0;
		end
		// Command bytes leave one at a time; the response is awaited after the last. [R2]
		if (s_reg.cmd_v && cmd_ready_i) begin
			if (s_reg.cmd_l) begin
				s_next.cmd_v = 1'b0;
			end else begin
				s_next.idx = s_reg.idx + 8'h01;
				s_next.cmd_d = cmd_byte(s_reg, s_next.idx);
				s_next.cmd_l = (s_next.idx == s_reg.len + 8'h02);
			end
		end
		// Response header fields are captured by position. [R4]
		take = s_reg.rsp_rdy && rsp_valid_i;
		if (take) begin
			if (s_reg.ridx != ccl_pkg::HDR_DATA) begin
				s_next.ridx = s_reg.ridx + 4'h1;
			end
			case (s_reg.ridx)
				ccl_pkg::HDR_INSTR_HI: s_next.instr[15:8] = rsp_data_i;
				ccl_pkg::HDR_INSTR_LO: s_next.instr[7:0] = rsp_data_i;
				ccl_pkg::HDR_PDU:      s_next.rpdu = rsp_data_i;
				ccl_pkg::HDR_FINAL:    s_next.rfin = rsp_data_i;
				default:               s_next.instr = s_next.instr;
			endcase
			ins = s_next.instr;
			fin = s_next.rfin;
			pn = s_next.rpdu;
			// Payload goes to the center untouched, last byte on the final PDU. [R16] [R19]
			if (s_reg.ridx == ccl_pkg::HDR_DATA && relay_kind(s_reg.kind)
				&& s_reg.st == ccl_pkg::CCL_COMM && !s_reg.drop_wait) begin
				s_next.push_v = 1'b1;
				s_next.push_d = {rsp_last_i && (pn == fin), rsp_data_i};
			end
			if (rsp_last_i) begin
				s_next.busy = 1'b0;
				s_next.ridx = '0;
				// Multi-part answers are fetched in increasing PDU order. [R6] [R17]
				if (relay_kind(s_reg.kind) && s_reg.st == ccl_pkg::CCL_COMM
					&& fin != 8'h00 && pn != fin && !s_reg.drop_wait) begin
					s_next.kind = ccl_pkg::CMD_REQ_DATA;
					s_next.pdu = pn + 8'h01; // [R7]
					s_next.len = '0;
					launch = 1'b1;
				end
				case (ins)
					ccl_pkg::INS_CALLIN: begin
						// Only an idle receiver dials; repeats are discarded. [R9] [R12]
						if (s_reg.st == ccl_pkg::CCL_IDLE) begin
							s_next.st = ccl_pkg::CCL_CALLIN;
							s_next.dial = 1'b1;
							s_next.retries = 1'b0;
						end
					end
					ccl_pkg::INS_RETRIES: s_next.retries = 1'b1;
					ccl_pkg::INS_DISCONNECT, ccl_pkg::INS_CENTER_ERR: begin
						// Cancel call-in or hang up; idle ignores it. [R21] [R22] [R23]
						if (s_reg.st != ccl_pkg::CCL_IDLE) begin
							s_next.st = ccl_pkg::CCL_IDLE;
							s_next.hangup = 1'b1;
							s_next.drop_wait = 1'b0;
							s_next.conn_p = 1'b0;
							s_next.fail_p = 1'b0;
							s_next.fault_p = 1'b0;
							s_next.buf_cnt = '0;
							s_next.flush = 1'b0;
							s_next.part_no = '0;
							launch = 1'b0;
						end
					end
					default: s_next.instr = s_next.instr; // [R24]
				endcase
			end
		end
		// Center bytes are gathered into numbered partitions. [R8]
		if (s_reg.ctr_rdy && ctr_in_valid_i) begin
			s_next.buf_d[s_reg.buf_cnt[3:0]] = ctr_in_data_i;
			s_next.buf_cnt = s_reg.buf_cnt + 5'h01;
			if (ctr_in_last_i || s_next.buf_cnt == ccl_pkg::PART_FULL) begin
				s_next.flush = 1'b1;
				s_next.flush_end = ctr_in_last_i;
			end
		end
		if (!s_reg.busy && !launch) begin
			launch = 1'b1;
			s_next.len = '0;
			s_next.pdu = '0;
			if (s_reg.fail_p) begin
				s_next.fail_p = dial_fail_i && s_reg.st == ccl_pkg::CCL_CALLIN;
				s_next.kind = ccl_pkg::CMD_REPORT; // [R11]
				s_next.status = ccl_pkg::STS_FAILED;
				s_next.len = ccl_pkg::LEN_STATUS;
				s_next.st = ccl_pkg::CCL_IDLE;
				s_next.conn_p = 1'b0;
			end else if (s_reg.conn_p) begin
				s_next.conn_p = connected_i && s_reg.st == ccl_pkg::CCL_CALLIN;
				s_next.kind = ccl_pkg::CMD_REPORT; // [R10]
				s_next.status = ccl_pkg::STS_COMPLETE;
				s_next.len = ccl_pkg::LEN_STATUS;
				s_next.st = ccl_pkg::CCL_COMM;
			end else if (s_reg.fault_p && !s_reg.drop_wait) begin
				s_next.fault_p = comm_fault_i && s_reg.st == ccl_pkg::CCL_COMM;
				s_next.kind = ccl_pkg::CMD_REPORT; // [R21]
				s_next.status = ccl_pkg::STS_DISCONNECTED;
				s_next.len = ccl_pkg::LEN_STATUS;
				s_next.drop_wait = 1'b1;
			end else if (s_reg.flush && !s_reg.drop_wait) begin
				s_next.kind = ccl_pkg::CMD_CENTER_RSP; // [R18]
				s_next.len = {3'b000, s_reg.buf_cnt};
				s_next.pdu = s_reg.part_no; // [R7] [R8]
				s_next.part_no = s_reg.flush_end ? 8'h00 : s_reg.part_no + 8'h01;
				s_next.flush = 1'b0;
				s_next.buf_cnt = '0;
			end else if (user_callin_i && s_reg.retries && s_reg.st == ccl_pkg::CCL_IDLE) begin
				s_next.kind = ccl_pkg::CMD_USER_CALL; // [R14]
			end else if (poll_i) begin
				s_next.kind = ccl_pkg::CMD_POLL;
			end else begin
				launch = 1'b0; // [R24]
			end
		end
		// Launch places the length byte first, then the PDU number. [R3] [R1]
		if (launch) begin
			s_next.busy = 1'b1;
			s_next.cmd_v = 1'b1;
			s_next.idx = ccl_pkg::CMD_POS_LC;
			s_next.cmd_d = s_next.len + 8'h01;
			s_next.cmd_l = 1'b0;
		end
		s_next.rsp_rdy = s_next.busy && !s_next.cmd_v && !s_next.push_v;
		s_next.ctr_rdy = s_next.st == ccl_pkg::CCL_COMM && !s_next.drop_wait && !s_next.busy
			&& !s_next.flush && s_next.buf_cnt != ccl_pkg::PART_FULL;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	ccl_fifo #(
		.WIDTH(ccl_pkg::FIFO_WIDTH),
		.DEPTH(ccl_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.in_valid_i (s_reg.push_v),
		.in_data_i  (s_reg.push_d),
		.in_ready_o (fifo_rdy),
		.out_valid_o(ctr_out_valid_o),
		.out_data_o (fifo_out),
		.out_ready_i(ctr_out_ready_i)
	);

	assign ctr_out_data_o = fifo_out[7:0];
	assign ctr_out_last_o = fifo_out[8];
	assign cmd_valid_o = s_reg.cmd_v; // [R5]
	assign cmd_data_o = s_reg.cmd_d;
	assign cmd_last_o = s_reg.cmd_l;
	assign rsp_ready_o = s_reg.rsp_rdy;
	assign ctr_in_ready_o = s_reg.ctr_rdy;
	assign dial_o = s_reg.dial;
	assign hangup_o = s_reg.hangup;
	assign state_o = s_reg.st;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	one_outstanding_a: assert property ($rose(cmd_valid_o) // [R2]
		|-> $past(!s_reg.busy || (rsp_ready_o && rsp_valid_i && rsp_last_i)))
		else $error("command started while one was outstanding");
	resp_when_busy_a: assert property (rsp_ready_o |-> s_reg.busy && !cmd_valid_o) // [R2]
		else $error("response taken with no command pending");
	length_first_a: assert property ($rose(cmd_valid_o) |-> cmd_data_o == s_reg.len + 8'h01) // [R3]
		else $error("command did not open with its length byte");
	pdu_second_a: assert property (cmd_valid_o && cmd_ready_i && s_reg.idx == 8'h00 && !cmd_last_o
		|=> cmd_data_o == s_reg.pdu) // [R3]
		else $error("second command byte is not the PDU number");
	pdu_order_a: assert property ($rose(cmd_valid_o) && s_reg.kind == ccl_pkg::CMD_REQ_DATA
		|-> s_reg.pdu == $past(s_reg.rpdu) + 8'h01) // [R6]
		else $error("request-data PDU number out of order");
	dial_idle_a: assert property (dial_o |-> state_o == ccl_pkg::CCL_CALLIN
		&& $past(state_o) == ccl_pkg::CCL_IDLE) // [R9]
		else $error("dial outside an idle call-in start");
	no_redial_a: assert property ($past(state_o) == ccl_pkg::CCL_CALLIN |-> !dial_o) // [R12]
		else $error("repeated call-in restarted dialing");
	conn_report_a: assert property (state_o == ccl_pkg::CCL_COMM
		&& $past(state_o) == ccl_pkg::CCL_CALLIN
		|-> cmd_valid_o && s_reg.status == ccl_pkg::STS_COMPLETE) // [R10]
		else $error("communications entered without complete report");
	fail_report_a: assert property ($past(state_o) == ccl_pkg::CCL_CALLIN
		&& state_o == ccl_pkg::CCL_IDLE && !hangup_o
		|-> cmd_valid_o && s_reg.status == ccl_pkg::STS_FAILED) // [R11]
		else $error("call-in abandoned without failed report");
	user_gate_a: assert property ($rose(cmd_valid_o) && s_reg.kind == ccl_pkg::CMD_USER_CALL
		|-> s_reg.retries) // [R14]
		else $error("user call-in sent before retries exceeded");
	hangup_idle_a: assert property (hangup_o |-> state_o == ccl_pkg::CCL_IDLE
		&& $past(state_o) != ccl_pkg::CCL_IDLE) // [R22] [R23]
		else $error("hang-up without leaving an active state");

	callin_cov: cover property (dial_o ##[1:200] state_o == ccl_pkg::CCL_COMM);
	multi_pdu_cov: cover property ($rose(cmd_valid_o) && s_reg.kind == ccl_pkg::CMD_REQ_DATA);
	fault_cov: cover property (s_reg.drop_wait ##[1:200] hangup_o);
endmodule : ccl_ctrl
`default_nettype wire

// ### test/ccl_card_model.sv
// Card-side model of the call-in link: takes whole commands, answers each with one response.
// Assumes the bench sets the instruction, final PDU number and payload length to return.
`timescale 1ns/1ps
`default_nettype none
module ccl_card_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_data_i,
	input  wire logic        cmd_last_i,
	output logic             cmd_ready_o,
	output logic             rsp_valid_o,
	output logic [7:0]       rsp_data_o,
	output logic             rsp_last_o,
	input  wire logic        rsp_ready_i,
	input  wire logic        slow_i,
	input  wire logic [15:0] ins_i,
	input  wire logic [7:0]  fin_i,
	input  wire logic [3:0]  plen_i
);
	logic [7:0] cur[$];
	logic [7:0] hdr[8];
	logic [7:0] code;
	logic [7:0] pdu;
	logic [7:0] arg;
	logic [7:0] lc;
	int         ncmd;
	int         ndone;
	int         nbytes;

	// A slow card toggles its ready so the controller must hold each byte.
	always @(negedge mclk_i or posedge rst_i) begin
		if (rst_i)
			cmd_ready_o <= 1'b0;
		else
			cmd_ready_o <= slow_i ? ~cmd_ready_o : 1'b1;
	end

	task automatic put(input logic [7:0] b, input logic l);
		@(negedge mclk_i);
		if (slow_i) begin
			rsp_valid_o = 1'b0;
			rsp_data_o  = ~rsp_data_o;
			@(negedge mclk_i);
		end
		rsp_valid_o = 1'b1;
		rsp_data_o  = b;
		rsp_last_o  = l;
		do
			@(posedge mclk_i);
		while (rsp_ready_i !== 1'b1);
	endtask : put

	// ------------------------------------------------------------------
	// Slave answers only after a whole command has arrived.
	// ------------------------------------------------------------------
	initial begin
		rsp_valid_o = 1'b0;
		rsp_data_o  = 8'h00;
		rsp_last_o  = 1'b0;
		forever begin
			@(posedge mclk_i);
			if (!rst_i && cmd_valid_i && cmd_ready_o) begin
				cur.push_back(cmd_data_i);
				if (cmd_last_i) begin
					lc     = cur[0];
					pdu    = cur[1];
					code   = cur[2];
					arg    = (cur.size() > 3) ? cur[3] : 8'h00;
					nbytes = cur.size();
					cur.delete();
					ncmd++;
					hdr = '{8'h01, 8'h06 + {4'h0, plen_i}, ins_i[15:8], ins_i[7:0],
						8'h00, 8'h00, pdu, fin_i};
					for (int i = 0; i < 8 + plen_i; i++)
						put((i < 8) ? hdr[i] : {pdu[3:0], 4'(i - 8)}, i == 7 + plen_i);
					@(negedge mclk_i);
					rsp_valid_o = 1'b0;
					rsp_data_o  = ~rsp_data_o;
					rsp_last_o  = 1'b0;
					ndone++;
				end
			end
		end
	end
endmodule : ccl_card_model
`default_nettype wire

// ### test/ccl_ctrl_tb_top.sv
// Self-checking bench of the call-in link controller against a card model.
// Assumes the package, the controller and the card model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ccl_ctrl_tb_top;
	logic            mclk_i = 1'b0;
	logic            rst_i  = 1'b1;
	logic [4:0]      ev     = 5'h00;
	logic            slow   = 1'b0;
	logic [15:0]     ins    = 16'h0000;
	logic [7:0]      fin    = 8'h00;
	logic [3:0]      plen   = 4'h0;
	logic            civ    = 1'b0;
	logic [7:0]      cid    = 8'h00;
	logic            cil    = 1'b0;
	logic            cor    = 1'b0;
	wire logic       cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready;
	wire logic       dial, hang, cir, cov, col;
	wire logic [7:0] cmd_data, rsp_data, cod;
	wire logic [1:0] state;
	int              failures, num_checks, n_dial, n_hang, nexp;
	logic [8:0]      outq[$];

	ccl_ctrl ccl_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_o(cmd_valid),
		.cmd_data_o(cmd_data), .cmd_last_o(cmd_last), .cmd_ready_i(cmd_ready),
		.rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .rsp_last_i(rsp_last),
		.rsp_ready_o(rsp_ready), .poll_i(ev[0]), .user_callin_i(ev[1]), .dial_o(dial),
		.connected_i(ev[2]), .dial_fail_i(ev[3]), .comm_fault_i(ev[4]), .hangup_o(hang),
		.ctr_in_valid_i(civ), .ctr_in_data_i(cid), .ctr_in_last_i(cil), .ctr_in_ready_o(cir),
		.ctr_out_valid_o(cov), .ctr_out_data_o(cod), .ctr_out_last_o(col),
		.ctr_out_ready_i(cor), .state_o(state));

	ccl_card_model ccl_card_model_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data), .cmd_last_i(cmd_last),
		.cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.rsp_last_o(rsp_last), .rsp_ready_i(rsp_ready), .slow_i(slow), .ins_i(ins),
		.fin_i(fin), .plen_i(plen));

	always #20 mclk_i = ~mclk_i;

	always @(posedge mclk_i) begin
		if (dial === 1'b1)
			n_dial++;
		if (hang === 1'b1)
			n_hang++;
		if (cov === 1'b1 && cor)
			outq.push_back({col, cod});
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic tick(inout int k);
		k++;
		if (k > 2000) begin
			failures++;
			$display("unexpected wait length: expected %0d, seen %0d", 2000, k);
			end_of_test();
		end
	endtask : tick

	task automatic pulse(input int b);
		@(negedge mclk_i);
		ev[b] = 1'b1;
		@(negedge mclk_i);
		ev[b] = 1'b0;
	endtask : pulse

	task automatic wait_done(input int add);
		int k;
		k    = 0;
		nexp = nexp + add;
		while (ccl_card_model_inst.ndone < nexp) begin
			@(negedge mclk_i);
			tick(k);
		end
		repeat (3) @(negedge mclk_i);
	endtask : wait_done

	task automatic chk_cmd(input logic [7:0] code, input logic [7:0] arg, input logic [7:0] lc);
		chk("command code", {8'h00, code}, {8'h00, ccl_card_model_inst.code});
		chk("command payload", {8'h00, arg}, {8'h00, ccl_card_model_inst.arg});
		chk("command length", {8'h00, lc}, {8'h00, ccl_card_model_inst.lc});
	endtask : chk_cmd

	task automatic callin();
		ins = ccl_pkg::INS_CALLIN;
		pulse(0);
		wait_done(1);
	endtask : callin

	// ------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------
	task automatic t_idle();
		chk("reset outputs", 16'h0000, {11'h000, state, cmd_valid, dial, hang});
		pulse(1);
		repeat (10) @(negedge mclk_i);
		chk("blocked user command", 16'h0000, 16'(ccl_card_model_inst.ncmd));
		ins = ccl_pkg::INS_DISCONNECT;
		pulse(0);
		wait_done(1);
		chk_cmd(ccl_pkg::CMD_POLL, 8'h00, 8'h01);
		chk("poll pdu", 16'h0000, {8'h00, ccl_card_model_inst.pdu});
		chk("idle disconnect", 16'h0000, {14'h0000, state} | 16'(n_hang));
	endtask : t_idle

	task automatic t_callin();
		callin();
		chk("dial and state", 16'h0101, {8'(n_dial), 6'h00, state});
		callin();
		chk("repeat dropped", 16'h0101, {8'(n_dial), 6'h00, state});
		ins = 16'h0000;
		pulse(3);
		wait_done(1);
		chk_cmd(ccl_pkg::CMD_REPORT, ccl_pkg::STS_FAILED, 8'h02);
		chk("state after fail", 16'h0000, {14'h0000, state});
		callin();
		ins = ccl_pkg::INS_DISCONNECT;
		pulse(0);
		wait_done(1);
		chk("cancel call-in", 16'h0100, {8'(n_hang), 6'h00, state});
		callin();
		ins = 16'h0000;
		pulse(2);
		wait_done(1);
		chk_cmd(ccl_pkg::CMD_REPORT, ccl_pkg::STS_COMPLETE, 8'h02);
		chk("state after connect", 16'h0302, {8'(n_dial), 6'h00, state});
	endtask : t_callin

	task automatic t_relay();
		int k;
		k    = 0;
		fin  = 8'h02;
		plen = 4'h6;
		slow = 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk_i);
			civ = 1'b1;
			cid = 8'ha1 + 8'(i);
			cil = (i == 2);
			do begin
				@(posedge mclk_i);
				tick(k);
			end while (cir !== 1'b1);
		end
		@(negedge mclk_i);
		civ = 1'b0;
		cid = ~cid;
		cil = 1'b0;
		repeat (80) @(negedge mclk_i);
		chk("card stalled", 16'(nexp), 16'(ccl_card_model_inst.ndone));
		chk("fifo holds", 16'h0001, {15'h0000, cov} | 16'(outq.size()));
		chk_cmd(ccl_pkg::CMD_CENTER_RSP, 8'ha1, 8'h04);
		chk("partition", 16'h0006, {ccl_card_model_inst.pdu, 8'(ccl_card_model_inst.nbytes)});
		cor = 1'b1;
		wait_done(3);
		repeat (8) @(negedge mclk_i);
		chk_cmd(ccl_pkg::CMD_REQ_DATA, 8'h00, 8'h01);
		chk("last pdu", 16'h0002, {8'h00, ccl_card_model_inst.pdu});
		chk("relayed count", 16'h0012, 16'(outq.size()));
		for (int i = 0; i < 18 && i < outq.size(); i++)
			chk("relayed byte", {7'h00, i == 17, 4'(i / 6), 4'(i % 6)}, {7'h00, outq[i]});
		fin  = 8'h00;
		plen = 4'h0;
		slow = 1'b0;
	endtask : t_relay

	task automatic t_fault();
		ins = ccl_pkg::INS_DISCONNECT;
		pulse(4);
		wait_done(1);
		chk_cmd(ccl_pkg::CMD_REPORT, ccl_pkg::STS_DISCONNECTED, 8'h02);
		chk("hang up", 16'h0200, {8'(n_hang), 6'h00, state});
	endtask : t_fault

	task automatic t_user();
		ins = ccl_pkg::INS_RETRIES;
		pulse(0);
		wait_done(1);
		ins = ccl_pkg::INS_CALLIN;
		pulse(1);
		wait_done(1);
		chk_cmd(ccl_pkg::CMD_USER_CALL, 8'h00, 8'h01);
		chk("user call-in", 16'h0401, {8'(n_dial), 6'h00, state});
		ins = 16'h0000;
		pulse(2);
		wait_done(1);
		ins = ccl_pkg::INS_CENTER_ERR;
		pulse(0);
		wait_done(1);
		chk("center error", 16'h0300, {8'(n_hang), 6'h00, state});
	endtask : t_user

	initial begin
		repeat (20) @(negedge mclk_i);
		rst_i = 1'b0;
		t_idle();
		t_callin();
		t_relay();
		t_fault();
		t_user();
		end_of_test();
	end
endmodule : ccl_ctrl_tb_top
`default_nettype wire
